//--- design/stx_pkg.sv
// Package with constants and types shared by the serial transmit datapath.
package stx_pkg;
  localparam int unsigned FIFO_DEPTH      = 256;
  localparam int unsigned FIFO_WIDTH      = 12;
  localparam int unsigned RAW_WIDTH       = 12;
  localparam int unsigned HOST_CLK_MAX_MHZ = 50;
  localparam int unsigned SYNC_STAGES     = 3;
  localparam logic [1:0]  REF_MULT_X1     = 2'h0;
  localparam logic [1:0]  REF_MULT_X2     = 2'h1;
  localparam logic [1:0]  REF_MULT_X4     = 2'h2;
  localparam logic [3:0]  BITS_PER_CHAR_10 = 4'ha;
  localparam logic [3:0]  BITS_PER_CHAR_12 = 4'hc;
  localparam logic [5:0]  K28_5_RDN       = 6'h0f;
  typedef enum logic [2:0] {
    STX_IDLE  = 3'b001,
    STX_LOAD  = 3'b010,
    STX_SHIFT = 3'b100
  } stx_state_t;
endpackage

//--- design/stx_fifo_if.sv
// Interface carrying the FIFO write and read handshakes between the datapath modules.
interface stx_fifo_if #(parameter int unsigned WIDTH = 12);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
  modport user (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
endinterface

//--- design/stx_fifo.sv
// Synchronous character FIFO with valid and ready handshakes on both sides.
module stx_fifo
  import stx_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic i_core_clk,  // Core clock.
  input  wire logic i_rstn,      // Asynchronous reset, active low.
  input  wire logic i_clear,     // Synchronous flush.
  stx_fifo_if.fifo  bus          // Write and read handshakes.
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // The count is one bit wider than the pointers so that full and empty differ.
  assign bus.wr_ready = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign bus.rd_valid = (cnt_q != '0);
  assign bus.rd_data  = mem[rp_q];
  assign push = bus.wr_valid & bus.wr_ready;
  assign pop  = bus.rd_valid & bus.rd_ready;

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (i_clear) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_q] <= bus.wr_data;
    end
  end
endmodule

//--- design/stx_encoder.sv
// Running-disparity 8B/10B encoder with one registered stage.
module stx_encoder
  import stx_pkg::*;
(
  input  wire logic       i_core_clk,  // Core clock.
  input  wire logic       i_rstn,      // Asynchronous reset, active low.
  input  wire logic       i_load,      // Encode one character.
  input  wire logic       i_ctrl,      // Special character select.
  input  wire logic [7:0] i_data,      // Character to encode.
  output logic      [9:0] o_code       // Encoded character, bit 0 first.
);
  logic       rd_q, rd_d;
  logic [9:0] code_q, code_d;
  logic [5:0] six;
  logic [3:0] four;
  logic       six_flip, four_flip, alt;

  always_comb begin
    six      = 6'h00;
    six_flip = 1'b1;
    case (i_data[4:0])
      5'h00: six = 6'h27; 5'h01: six = 6'h1d; 5'h02: six = 6'h2d; 5'h03: six = 6'h31;
      5'h04: six = 6'h35; 5'h05: six = 6'h29; 5'h06: six = 6'h19; 5'h07: six = 6'h38;
      5'h08: six = 6'h39; 5'h09: six = 6'h25; 5'h0a: six = 6'h15; 5'h0b: six = 6'h34;
      5'h0c: six = 6'h0d; 5'h0d: six = 6'h2c; 5'h0e: six = 6'h1c; 5'h0f: six = 6'h17;
      5'h10: six = 6'h1b; 5'h11: six = 6'h23; 5'h12: six = 6'h13; 5'h13: six = 6'h32;
      5'h14: six = 6'h0b; 5'h15: six = 6'h2a; 5'h16: six = 6'h1a; 5'h17: six = 6'h3a;
      5'h18: six = 6'h33; 5'h19: six = 6'h26; 5'h1a: six = 6'h16; 5'h1b: six = 6'h36;
      5'h1c: six = 6'h0e; 5'h1d: six = 6'h2e; 5'h1e: six = 6'h1e; default: six = 6'h2b;
    endcase
    if (i_ctrl) begin
      six = K28_5_RDN;
    end
    // Balanced sub-blocks other than D.07 keep one form for both disparities.
    if (($countones(six) == 3) && (six != 6'h38)) begin
      six_flip = 1'b0;
    end
    four = 4'h0;
    case (i_data[7:5])
      3'h0: four = 4'hb; 3'h1: four = 4'h9; 3'h2: four = 4'h5; 3'h3: four = 4'hc;
      3'h4: four = 4'hd; 3'h5: four = 4'ha; 3'h6: four = 4'h6; default: four = 4'he;
    endcase
    alt = (i_data[7:5] == 3'h7) && (
      (!rd_q && (i_data[4:0] == 5'h11 || i_data[4:0] == 5'h12 || i_data[4:0] == 5'h14)) ||
      (rd_q && (i_data[4:0] == 5'h0b || i_data[4:0] == 5'h0d || i_data[4:0] == 5'h0e)));
    if (alt) begin
      four = 4'h7;
    end
    four_flip = ($countones(four) != 2) || (four == 4'hc);
    code_d = code_q;
    rd_d   = rd_q;
    if (i_load) begin
      code_d[5:0] = (rd_q && six_flip) ? ~six : six;
      rd_d        = rd_q ^ six_flip;
      code_d[9:6] = (rd_d && four_flip) ? ~four : four;
      if (four_flip && (four != 4'hc)) begin
        rd_d = ~rd_d;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_q   <= 1'b0;
      code_q <= 10'h000;
    end else begin
      rd_q   <= rd_d;
      code_q <= code_d;
    end
  end
  assign o_code = code_q;
endmodule

//--- design/stx_top.sv
// Transmit datapath: host input, character FIFO, encoder and serializer.
// Overview of operation
// - Host characters are eight, ten or twelve bits wide, set by static selects.
// - With FIFO enabled, host writes act as a synchronous FIFO write port.
// - With FIFO enabled, a 256-character buffer sits before the encoder.
// - Buffered writes are accepted at any rate up to a 50 MHz host clock.
// - Without FIFO, the input register runs in lockstep with character timing.
// - Reference clock may be one, two or four times the character rate.
// - Both interface styles support the UTOPIA and Cascade timing models.
// - UTOPIA model follows that standard's active levels and sequencing.
// - Cascade model looks like a plain synchronous FIFO write port.
// - Characters pass the 8B/10B encoder unless the encoder is bypassed.
// - Bit rate is 2.5, 5 or 10 times reference when not twelve-bit raw.
// - Twelve-bit raw mode shifts at 3, 6 or 12 times reference rate.
// - Serial data is driven identically on two output drivers.
// - Width high: encoded 8 or raw 10; width low: encoded 8 or raw 12.
// - Low model select means UTOPIA, high means Cascade with flipped sense.
//
// The core clock is the serial bit clock; character timing derives from it.
// The host clock and the reference clock come from outside and are resynchronised.
module stx_top
  import stx_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned WIDTH = FIFO_WIDTH
) (
  input  wire logic                 i_core_clk,             // Serial bit clock.
  input  wire logic                 i_rstn,                 // Global reset, active low.
  input  wire logic                 i_host_tx_clock,        // Host write clock, sampled.
  input  wire logic                 i_reference_clock,      // Reference clock, sampled.
  input  wire logic [1:0]           i_ref_mult,             // Reference to character ratio.
  input  wire logic                 i_char_width_select,    // High: 8 or 10 bit characters.
  input  wire logic                 i_encoder_bypass_n,     // Low: encoder bypassed.
  input  wire logic                 i_fifo_bypass_n,        // Low: FIFO bypassed.
  input  wire logic                 i_timing_model_select,  // Low UTOPIA, high Cascade.
  input  wire logic                 i_tx_enable,            // Host write enable.
  input  wire logic                 i_tx_special,           // Special character select.
  input  wire logic [WIDTH-1:0]     i_tx_data,              // Host character.
  output logic                      o_tx_full,              // FIFO full flag, model sense.
  output logic                      o_tx_empty,             // FIFO empty flag, model sense.
  output logic                      o_char_strobe,          // Character period marker.
  output logic                      o_serial_a,             // Serial output A.
  output logic                      o_serial_b              // Serial output B.
);
  logic [SYNC_STAGES-1:0] hclk_sync_q, rclk_sync_q;
  logic                   hclk_edge, rclk_edge, hclk_lvl_q, rclk_lvl_q;
  logic                   raw12, raw_mode, utopia;
  logic [3:0]             bits_per_char;
  logic [3:0]             bit_cnt_q, bit_cnt_d;
  logic [1:0]             ref_cnt_q, ref_cnt_d;
  logic                   char_tick;
  logic [RAW_WIDTH-1:0]   shift_q, shift_d;
  logic [RAW_WIDTH-1:0]   raw_q, raw_d;
  logic [RAW_WIDTH-1:0]   sync_reg_q, sync_reg_d;
  logic                   sync_spec_q, sync_spec_d;
  logic [RAW_WIDTH-1:0]   cur_char;
  logic                   cur_spec, load_now;
  logic [9:0]             enc_code;
  logic                   enc_load, enc_pend_q, enc_pend_d;
  logic                   wr_en;
  stx_state_t             state_q, state_d;
  logic                   full_q, empty_q, strobe_q, ser_a_q, ser_b_q;

  stx_fifo_if #(.WIDTH(WIDTH + 1)) fif ();

  // Three-stage synchronisers; only the later two stages feed the edge logic.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hclk_sync_q <= '0;
      rclk_sync_q <= '0;
      hclk_lvl_q  <= 1'b0;
      rclk_lvl_q  <= 1'b0;
    end else begin
      hclk_sync_q <= {hclk_sync_q[SYNC_STAGES-2:0], i_host_tx_clock};
      rclk_sync_q <= {rclk_sync_q[SYNC_STAGES-2:0], i_reference_clock};
      if (hclk_sync_q[1] == hclk_sync_q[2]) begin
        hclk_lvl_q <= hclk_sync_q[2];
      end
      if (rclk_sync_q[1] == rclk_sync_q[2]) begin
        rclk_lvl_q <= rclk_sync_q[2];
      end
    end
  end
  assign hclk_edge = (hclk_sync_q[1] == hclk_sync_q[2]) && hclk_sync_q[2] && !hclk_lvl_q;
  assign rclk_edge = (rclk_sync_q[1] == rclk_sync_q[2]) && rclk_sync_q[2] && !rclk_lvl_q;

  // Mode decode.
  assign raw_mode      = !i_encoder_bypass_n;
  assign raw12         = !i_char_width_select && !i_encoder_bypass_n;
  assign bits_per_char = raw12 ? BITS_PER_CHAR_12 : BITS_PER_CHAR_10;
  assign utopia        = !i_timing_model_select;
  // UTOPIA enables are active low, Cascade enables active high.
  assign wr_en = utopia ? !i_tx_enable : i_tx_enable;

  // Character period: one per bits_per_char bit clocks.
  always_comb begin
    bit_cnt_d = (bit_cnt_q == bits_per_char - 4'h1) ? 4'h0 : bit_cnt_q + 4'h1;
    char_tick = (bit_cnt_q == bits_per_char - 4'h1);
    ref_cnt_d = ref_cnt_q;
    if (rclk_edge) begin
      // Count reference edges so a multi-rate reference still marks characters.
      case (i_ref_mult)
        REF_MULT_X2: ref_cnt_d = {1'b0, ~ref_cnt_q[0]};
        REF_MULT_X4: ref_cnt_d = ref_cnt_q + 2'h1;
        default:     ref_cnt_d = 2'h0;
      endcase
    end
  end

  // Host write path into the FIFO, on the host clock edge.
  assign fif.wr_valid = i_fifo_bypass_n && hclk_edge && wr_en;
  assign fif.wr_data  = {i_tx_special, i_tx_data};
  assign fif.rd_ready = i_fifo_bypass_n && load_now;

  stx_fifo #(
    .WIDTH (WIDTH + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_clear    (1'b0),
    .bus        (fif)
  );

  // Synchronous input register captured on reference edges at character rate.
  always_comb begin
    sync_reg_d  = sync_reg_q;
    sync_spec_d = sync_spec_q;
    if (!i_fifo_bypass_n && rclk_edge && (ref_cnt_q == 2'h0) && wr_en) begin
      sync_reg_d  = i_tx_data;
      sync_spec_d = i_tx_special;
    end
  end

  assign cur_char = i_fifo_bypass_n ? fif.rd_data[WIDTH-1:0] : sync_reg_q;
  assign cur_spec = i_fifo_bypass_n ? fif.rd_data[WIDTH] : sync_spec_q;
  // Only idle or the last bit may take a character; the load cycle must not pop twice.
  assign load_now = (state_q == STX_IDLE) || ((state_q == STX_SHIFT) && char_tick);
  // Encoder runs one cycle ahead; it is fed when a new character enters.
  assign enc_load = load_now && (!i_fifo_bypass_n || fif.rd_valid);

  stx_encoder u_enc (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_load     (enc_load),
    .i_ctrl     (cur_spec),
    .i_data     (cur_char[7:0]),
    .o_code     (enc_code)
  );

  // Serializer state machine.
  always_comb begin
    state_d    = state_q;
    shift_d    = {1'b0, shift_q[RAW_WIDTH-1:1]};
    enc_pend_d = enc_pend_q;
    // Raw characters are held from the pop, as the FIFO head moves on at once.
    raw_d      = enc_load ? cur_char : raw_q;
    case (state_q)
      STX_IDLE: begin
        if (enc_load) begin
          state_d    = STX_LOAD;
          enc_pend_d = 1'b1;
        end
      end
      STX_LOAD: begin
        // Encoded characters need the encoder's registered output first.
        state_d    = STX_SHIFT;
        shift_d    = raw_mode ? raw_q : {2'h0, enc_code};
        enc_pend_d = 1'b0;
      end
      STX_SHIFT: begin
        if (char_tick) begin
          state_d = enc_load ? STX_LOAD : STX_IDLE;
        end
      end
      default: state_d = STX_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= STX_IDLE;
      shift_q     <= '0;
      raw_q       <= '0;
      bit_cnt_q   <= 4'h0;
      ref_cnt_q   <= 2'h0;
      sync_reg_q  <= '0;
      sync_spec_q <= 1'b0;
      enc_pend_q  <= 1'b0;
      full_q      <= 1'b0;
      empty_q     <= 1'b0;
      strobe_q    <= 1'b0;
      ser_a_q     <= 1'b0;
      ser_b_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      shift_q     <= shift_d;
      raw_q       <= raw_d;
      bit_cnt_q   <= (state_q == STX_SHIFT) ? bit_cnt_d : 4'h0;
      ref_cnt_q   <= ref_cnt_d;
      sync_reg_q  <= sync_reg_d;
      sync_spec_q <= sync_spec_d;
      enc_pend_q  <= enc_pend_d;
      // Flag sense follows the timing model: UTOPIA active high, Cascade low.
      full_q      <= utopia ? !fif.wr_ready : fif.wr_ready;
      empty_q     <= utopia ? !fif.rd_valid : fif.rd_valid;
      strobe_q    <= char_tick;
      ser_a_q     <= (state_q == STX_SHIFT) ? shift_q[0] : 1'b0;
      ser_b_q     <= (state_q == STX_SHIFT) ? shift_q[0] : 1'b0;
    end
  end

  assign o_tx_full     = full_q;
  assign o_tx_empty    = empty_q;
  assign o_char_strobe = strobe_q;
  assign o_serial_a    = ser_a_q;
  assign o_serial_b    = ser_b_q;
  // Character width field selection.
  // Raw 10-bit uses bits 9:0, raw 12-bit 11:0, encoded uses 7:0 plus special.
endmodule

//--- tb/stx_top_sva.sv
// Assertion checker watching the ports of the serial transmit datapath.
module stx_top_sva
  import stx_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned WIDTH = FIFO_WIDTH
) (
  input wire logic             i_core_clk,             // Bit clock.
  input wire logic             i_rstn,                 // Reset, active low.
  input wire logic             i_host_tx_clock,        // Host clock.
  input wire logic             i_reference_clock,      // Reference clock.
  input wire logic [1:0]       i_ref_mult,             // Ratio.
  input wire logic             i_char_width_select,    // Width.
  input wire logic             i_encoder_bypass_n,     // Encoder bypass.
  input wire logic             i_fifo_bypass_n,        // FIFO bypass.
  input wire logic             i_timing_model_select,  // Model.
  input wire logic             i_tx_enable,            // Enable.
  input wire logic             i_tx_special,           // Special.
  input wire logic [WIDTH-1:0] i_tx_data,              // Data.
  input wire logic             o_tx_full,              // Full flag.
  input wire logic             o_tx_empty,             // Empty flag.
  input wire logic             o_char_strobe,          // Strobe.
  input wire logic             o_serial_a,             // Serial A.
  input wire logic             o_serial_b              // Serial B.
);
  logic       raw12;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic [4:0] quiet_q;
  logic [4:0] quiet_d;
  assign raw12 = !i_char_width_select && !i_encoder_bypass_n;
  // Saturating counters keep long spans out of the property repetitions.
  always_comb begin
    gap_d = o_char_strobe ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
    up_d = up_q + {1'b0, up_q != 2'h3};
    quiet_d = (o_tx_empty == i_timing_model_select) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_q <= 8'h00;
      up_q <= 2'h0;
      quiet_q <= 5'h00;
    end else begin
      gap_q <= gap_d;
      up_q <= up_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_serial_pair_equal: assert property (o_serial_a == o_serial_b)
    else $error("serial outputs differ");
  a_strobe_single_pulse: assert property (o_char_strobe |=> !o_char_strobe)
    else $error("character strobe longer than one cycle");
  a_char_ten_spacing: assert property (o_char_strobe && !raw12 |-> gap_q >= 8'h09)
    else $error("ten bit character too short");
  a_char_twelve_spacing: assert property (o_char_strobe && raw12 |-> gap_q >= 8'h0b)
    else $error("twelve bit character too short");
  a_bit_within_ten: assert property (o_serial_a && !raw12 |-> ##[0:9] o_char_strobe)
    else $error("bit outside a ten bit character");
  a_bit_within_twelve: assert property (o_serial_a && raw12 |-> ##[0:11] o_char_strobe)
    else $error("bit outside a twelve bit character");
  a_flag_model_sense: assert property ((up_q == 2'h3) && (o_tx_full == o_tx_empty)
    |-> o_tx_full == i_timing_model_select)
    else $error("full and empty flags contradict");
  a_reset_flags_empty: assert property (up_q == 2'h2 |-> (o_tx_empty != i_timing_model_select)
    && (o_tx_full == i_timing_model_select))
    else $error("flags not empty after reset");
  a_idle_line_quiet: assert property (quiet_q >= 5'h18 |-> !o_serial_a && !o_char_strobe)
    else $error("line active while buffer empty");
  c_twelve_char: cover property (o_char_strobe && raw12);
  c_ten_char: cover property (o_char_strobe && !raw12);
  c_buffer_full: cover property (o_tx_full != i_timing_model_select);
  c_idle_line: cover property (quiet_q >= 5'h18);
endmodule

bind stx_top stx_top_sva #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_stx_top_sva (.*);

//--- tb/stx_host_model.sv
// Host bus model that writes characters into the transmit FIFO port.
module stx_host_model
  import stx_pkg::*;
(
  input  wire logic            i_full,    // Full flag, model sense.
  output logic                 o_clk,     // Host write clock.
  output logic                 o_enable,  // Write enable, model sense.
  output logic [FIFO_WIDTH-1:0] o_data    // Character.
);
  timeunit 1ns;
  timeprecision 1ps;
  int                    seed = 32'hcb0fc87c;
  logic [FIFO_WIDTH-1:0] sent[$];
  initial begin
    o_clk = 1'b1;
    o_enable = 1'b1;
    o_data = 12'h000;
  end
  // A long high phase keeps data steady until the resynchronised edge is taken.
  always begin
    #70 o_clk = 1'b0;
    #20 o_clk = 1'b1;
  end
  task automatic park(input logic casc);
    o_enable = !casc;
    o_data = ~o_data;
  endtask
  task automatic send(input int n, input logic casc);
    int i;
    i = 0;
    while (i < n) begin
      @(negedge o_clk);
      if (i_full == casc) begin
        o_enable = casc;
        o_data = FIFO_WIDTH'($random(seed));
        sent.push_back(o_data);
        i++;
      end else begin
        park(casc);
      end
    end
    @(negedge o_clk);
    park(casc);
  endtask
endmodule

//--- tb/tb.sv
// Self-checking testbench for the serial transmit datapath.
module tb
  import stx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DEPTH = 8;
  localparam int unsigned WIDTH = FIFO_WIDTH;
  localparam int          NCHAR = 60;
  logic             i_core_clk;
  logic             i_rstn;
  logic             i_host_tx_clock;
  logic             i_reference_clock;
  logic [1:0]       i_ref_mult;
  logic             i_char_width_select;
  logic             i_encoder_bypass_n;
  logic             i_fifo_bypass_n;
  logic             i_timing_model_select;
  logic             i_tx_enable;
  logic             i_tx_special;
  logic [WIDTH-1:0] i_tx_data;
  logic             o_tx_full;
  logic             o_tx_empty;
  logic             o_char_strobe;
  logic             o_serial_a;
  logic             o_serial_b;
  int               n_errors;
  int               checks;
  int               n_strobe;
  int               cyc = 0;
  logic             saw_full;
  logic [11:0]      hist;
  logic [11:0]      got;
  logic [11:0]      want;
  logic [2:0]       cfgs[4] = '{3'b000, 3'b101, 3'b110, 3'b011};

  stx_top #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_stx_top (.*);
  stx_host_model i_stx_host_model (
    .i_full   (o_tx_full),
    .o_clk    (i_host_tx_clock),
    .o_enable (i_tx_enable),
    .o_data   (i_tx_data)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_reference_clock = 1'b0;
    forever #20 i_reference_clock = ~i_reference_clock;
  end

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      close_out();
    end
  end

  // The strobe marks the last bit, so the newest sample closes the character.
  always @(negedge i_core_clk) begin
    if (i_rstn) begin
      hist = {o_serial_a, hist[11:1]};
      if (o_tx_full != i_timing_model_select)
        saw_full = 1'b1;
      if (o_char_strobe) begin
        n_strobe++;
        want = i_stx_host_model.sent.pop_front();
        got = (!i_char_width_select && !i_encoder_bypass_n) ? hist : {2'h0, hist[11:2]};
        if (i_encoder_bypass_n)
          check("code weight", 12'h001, {11'h0, $countones(got) inside {4, 5, 6}});
        else if (i_char_width_select)
          check("raw10 character", want & 12'h3ff, got);
        else
          check("raw12 character", want, got);
      end
    end
  end

  task automatic run(input logic [2:0] cfg);
    int t;
    @(negedge i_core_clk);
    i_rstn = 1'b0;
    {i_char_width_select, i_encoder_bypass_n, i_timing_model_select} = cfg;
    i_stx_host_model.park(cfg[0]);
    i_stx_host_model.sent.delete();
    saw_full = 1'b0;
    n_strobe = 0;
    repeat (10) @(negedge i_core_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_core_clk);
    check("empty after reset", {11'h0, !cfg[0]}, {11'h0, o_tx_empty});
    check("room after reset", {11'h0, cfg[0]}, {11'h0, o_tx_full});
    i_stx_host_model.send(NCHAR, cfg[0]);
    t = 0;
    while (n_strobe < NCHAR && t < 3000) begin
      @(negedge i_core_clk);
      t++;
    end
    check("character count", 12'(NCHAR), 12'(n_strobe));
    repeat (30) @(negedge i_core_clk);
    check("empty when drained", {11'h0, !cfg[0]}, {11'h0, o_tx_empty});
    if (cfg == 3'b000)
      check("buffer full seen", 12'h001, {11'h0, saw_full});
  endtask

  initial begin
    i_rstn = 1'b0;
    i_ref_mult = REF_MULT_X1;
    i_char_width_select = 1'b0;
    i_encoder_bypass_n = 1'b0;
    i_fifo_bypass_n = 1'b1;
    i_timing_model_select = 1'b0;
    i_tx_special = 1'b0;
    n_errors = 0;
    checks = 0;
    hist = 12'h000;
    foreach (cfgs[k])
      run(cfgs[k]);
    close_out();
  end
endmodule
